// ==== pkg/rlc_pkg.sv ====
package rlc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  TAG_TIMING_OFS = 8'h00;
    localparam logic [7:0]  DATA_TIMING_OFS = 8'h04;
    localparam logic [7:0]  ERR_STATUS_OFS = 8'h08;

    // ------------------------------------------------------------
    // field layout of both latency registers
    // ------------------------------------------------------------
    localparam int          LAT_FIELD_W    = 3;
    localparam int          SETUP_LSB      = 0;
    localparam int          READ_LSB       = 4;
    localparam int          WRITE_LSB      = 8;
    localparam logic [31:0] TIMING_MASK    = 32'h0000_0777;

    // error status bits
    localparam int          DECERR_BIT     = 0;
    localparam int          SLVERR_BIT     = 1;

    // ------------------------------------------------------------
    // htrans / hresp codes
    // ------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'h0;
    localparam logic        HRESP_ERROR    = 1'h1;

    // reset value of fields not set by parameters
    localparam logic [2:0]  LAT_ZERO       = 3'h0;

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_ERR1 = 3'b010,
        BUS_ERR2 = 3'b100
    } rlc_bus_t;

    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b001,
        SEQ_SETUP  = 3'b010,
        SEQ_ACCESS = 3'b100
    } rlc_seq_t;

endpackage

// ==== core/rlc_ram_seq.sv ====
`timescale 1ns/1ns
`default_nettype none
module rlc_ram_seq
    import rlc_pkg::*;
#(
    parameter int LAT_W = LAT_FIELD_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // latency settings
    input  wire logic [LAT_W-1:0] setup_lat,
    input  wire logic [LAT_W-1:0] read_lat,
    input  wire logic [LAT_W-1:0] write_lat,
    // access request
    input  wire logic             req,
    input  wire logic             req_we,
    output logic                  ready,
    output logic                  done,
    // ram strobes
    output logic                  ram_cs,
    output logic                  ram_we
);

    // a field needs at least one bit to hold a latency code
    if (LAT_W < 1) begin : g_bad_width
        $error("latency field width must be at least one");
    end

    rlc_seq_t         state;
    logic [LAT_W-1:0] cnt;
    logic [LAT_W-1:0] acc_lat;
    logic             we_q;

    // ------------------------------------------------------------
    // setup phase then access phase, each code+1 cycles
    // ------------------------------------------------------------
    // settings are latched at the start so a register write cannot
    // stretch or cut an access already in flight
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state   <= SEQ_IDLE;
            cnt     <= '0;
            acc_lat <= '0;
            we_q    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                SEQ_IDLE: begin
                    if (req) begin
                        state   <= SEQ_SETUP;
                        cnt     <= setup_lat;
                        acc_lat <= req_we ? write_lat : read_lat;
                        we_q    <= req_we;
                    end
                end
                SEQ_SETUP: begin
                    if (cnt == '0) begin
                        state <= SEQ_ACCESS;
                        cnt   <= acc_lat;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                SEQ_ACCESS: begin
                    if (cnt == '0) begin
                        state <= SEQ_IDLE;
                        done  <= 1'b1;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= SEQ_IDLE;
            endcase
        end
    end

    // strobes decoded from one-hot state flops
    assign ready  = (state == SEQ_IDLE);
    assign ram_cs = (state == SEQ_ACCESS);
    assign ram_we = ram_cs & we_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [LAT_W:0]   su_cnt;
    logic [LAT_W:0]   cs_cnt;
    logic [LAT_W-1:0] su_lat_q;

    // helper counters of phase lengths
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            su_cnt   <= '0;
            cs_cnt   <= '0;
            su_lat_q <= '0;
        end else if (ready && req) begin
            su_cnt   <= '0;
            cs_cnt   <= '0;
            su_lat_q <= setup_lat;
        end else begin
            if (state == SEQ_SETUP) su_cnt <= su_cnt + 1'b1;
            if (ram_cs) cs_cnt <= cs_cnt + 1'b1;
        end
    end

    sequence s_accept;
        ready && req;
    endsequence

    sequence s_setup_start;
        !ready && !ram_cs;
    endsequence

    a_accept_setup: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_accept |=> s_setup_start)
        else $error("access did not enter setup phase");

    a_setup_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(ram_cs) |-> su_cnt == {1'b0, su_lat_q} + 1'b1)
        else $error("setup phase length wrong");

    a_access_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done |-> cs_cnt == {1'b0, acc_lat} + 1'b1)
        else $error("access phase length wrong");

    a_done_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(ram_cs) |-> done && ready)
        else $error("done not raised at end of access");

endmodule
`default_nettype wire

// ==== core/rlc_top.sv ====
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rlc_top
    import rlc_pkg::*;
#(
    parameter int TAG_SETUP_DELAY_PARAM  = 0,
    parameter int TAG_READ_DELAY_PARAM   = 0,
    parameter int TAG_WRITE_DELAY_PARAM  = 0,
    parameter int DATA_SETUP_DELAY_PARAM = 0,
    parameter int DATA_READ_DELAY_PARAM  = 0,
    parameter int DATA_WRITE_DELAY_PARAM = 0
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    input  wire logic              hnonsec,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // cache enable from main control register
    input  wire logic              cache_enable,
    // tag ram access
    input  wire logic              tag_req,
    input  wire logic              tag_req_we,
    output logic                   tag_ready,
    output logic                   tag_done,
    output logic                   tag_ram_cs,
    output logic                   tag_ram_we,
    // data ram access
    input  wire logic              data_req,
    input  wire logic              data_req_we,
    output logic                   data_ready,
    output logic                   data_done,
    output logic                   data_ram_cs,
    output logic                   data_ram_we
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int LAT_MAX = (1 << LAT_FIELD_W) - 1;

    if (TAG_SETUP_DELAY_PARAM  < 0 || TAG_SETUP_DELAY_PARAM  > LAT_MAX ||
        TAG_READ_DELAY_PARAM   < 0 || TAG_READ_DELAY_PARAM   > LAT_MAX ||
        TAG_WRITE_DELAY_PARAM  < 0 || TAG_WRITE_DELAY_PARAM  > LAT_MAX ||
        DATA_SETUP_DELAY_PARAM < 0 || DATA_SETUP_DELAY_PARAM > LAT_MAX ||
        DATA_READ_DELAY_PARAM  < 0 || DATA_READ_DELAY_PARAM  > LAT_MAX ||
        DATA_WRITE_DELAY_PARAM < 0 || DATA_WRITE_DELAY_PARAM > LAT_MAX) begin : g_bad_lat
        $error("latency reset parameter out of range");
    end

    // reset words built from the build-time parameters
    localparam logic [31:0] TAG_RESET =
        (32'(TAG_WRITE_DELAY_PARAM) << WRITE_LSB) |
        (32'(TAG_READ_DELAY_PARAM)  << READ_LSB)  |
        (32'(TAG_SETUP_DELAY_PARAM) << SETUP_LSB);
    localparam logic [31:0] DATA_RESET =
        (32'(DATA_WRITE_DELAY_PARAM) << WRITE_LSB) |
        (32'(DATA_READ_DELAY_PARAM)  << READ_LSB)  |
        (32'(DATA_SETUP_DELAY_PARAM) << SETUP_LSB);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]       tag_ram_timing;
    logic [31:0]       data_ram_timing;
    logic [1:0]        err_status;
    rlc_bus_t          bus_state;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;

    // address phase decode
    logic acc_valid;
    logic hit_tag;
    logic hit_data;
    logic hit_stat;
    logic mapped;
    logic lat_wr;
    logic deny_ns;
    logic deny_en;
    logic refuse;

    assign acc_valid = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign hit_tag   = (haddr == TAG_TIMING_OFS);
    assign hit_data  = (haddr == DATA_TIMING_OFS);
    assign hit_stat  = (haddr == ERR_STATUS_OFS);
    assign mapped    = hit_tag || hit_data || hit_stat;
    assign lat_wr    = hwrite && (hit_tag || hit_data);
    assign deny_ns   = lat_wr && hnonsec;
    assign deny_en   = lat_wr && !hnonsec && cache_enable;
    assign refuse    = !mapped || deny_ns || deny_en;

    // ------------------------------------------------------------
    // bus response: ok in one data cycle, error in two
    // ------------------------------------------------------------
    // ahb-lite has one error code, so the decode and slave error cases
    // both answer ERROR and are told apart in the status register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (acc_valid && refuse) bus_state <= BUS_ERR1;
                end
                BUS_ERR1: bus_state <= BUS_ERR2;
                BUS_ERR2: begin
                    if (acc_valid && refuse) bus_state <= BUS_ERR1;
                    else bus_state <= BUS_IDLE;
                end
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

    assign hreadyout = (bus_state != BUS_ERR1);
    assign hresp     = (bus_state == BUS_IDLE) ? HRESP_OKAY : HRESP_ERROR;

    // accepted write waits for its data phase
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= acc_valid && hwrite && !refuse;
            if (acc_valid) wr_addr <= haddr;
        end
    end

    // ------------------------------------------------------------
    // latency registers
    // ------------------------------------------------------------
    // reserved bits are never stored, so they always read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tag_ram_timing  <= TAG_RESET;
            data_ram_timing <= DATA_RESET;
        end else if (wr_pend) begin
            if (wr_addr == TAG_TIMING_OFS) begin
                tag_ram_timing <= hwdata & TIMING_MASK;
            end else if (wr_addr == DATA_TIMING_OFS) begin
                data_ram_timing <= hwdata & TIMING_MASK;
            end
        end
    end

    // sticky refusal causes, a write of one clears, new refusal wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            err_status <= 2'h0;
        end else begin
            if (wr_pend && wr_addr == ERR_STATUS_OFS) begin
                err_status <= err_status & ~hwdata[1:0];
            end
            if (acc_valid && deny_ns) err_status[DECERR_BIT] <= 1'b1;
            if (acc_valid && deny_en) err_status[SLVERR_BIT] <= 1'b1;
        end
    end

    // read data captured in the address phase, any security state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (acc_valid && !hwrite) begin
            if (hit_tag) begin
                hrdata <= tag_ram_timing;
            end else if (hit_data) begin
                hrdata <= data_ram_timing;
            end else if (hit_stat) begin
                hrdata <= {30'h0, err_status};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // ram sequencers, one per array
    // ------------------------------------------------------------
    rlc_ram_seq #(.LAT_W(LAT_FIELD_W)) u_tag_seq (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .setup_lat (tag_ram_timing[SETUP_LSB +: LAT_FIELD_W]),
        .read_lat  (tag_ram_timing[READ_LSB +: LAT_FIELD_W]),
        .write_lat (tag_ram_timing[WRITE_LSB +: LAT_FIELD_W]),
        .req       (tag_req),
        .req_we    (tag_req_we),
        .ready     (tag_ready),
        .done      (tag_done),
        .ram_cs    (tag_ram_cs),
        .ram_we    (tag_ram_we)
    );

    rlc_ram_seq #(.LAT_W(LAT_FIELD_W)) u_data_seq (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .setup_lat (data_ram_timing[SETUP_LSB +: LAT_FIELD_W]),
        .read_lat  (data_ram_timing[READ_LSB +: LAT_FIELD_W]),
        .write_lat (data_ram_timing[WRITE_LSB +: LAT_FIELD_W]),
        .req       (data_req),
        .req_we    (data_req_we),
        .ready     (data_ready),
        .done      (data_done),
        .ram_cs    (data_ram_cs),
        .ram_we    (data_ram_we)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_error_resp;
        (hresp && !hreadyout) ##1 (hresp && hreadyout);
    endsequence

    a_ns_write_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && lat_wr && hnonsec |=> s_error_resp ##0 err_status[DECERR_BIT])
        else $error("non-secure write not refused");

    a_ns_write_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && lat_wr && hnonsec |-> ##2
        (tag_ram_timing == $past(tag_ram_timing, 2)) &&
        (data_ram_timing == $past(data_ram_timing, 2)))
        else $error("non-secure write changed a register");

    a_enabled_write_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && lat_wr && !hnonsec && cache_enable |=> s_error_resp)
        else $error("write with cache enabled not refused");

    a_read_tag_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && !hwrite && hit_tag |=>
        hreadyout && !hresp && hrdata == $past(tag_ram_timing))
        else $error("tag register read wrong");

    a_read_data_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && !hwrite && hit_data |=>
        hreadyout && !hresp && hrdata == $past(data_ram_timing))
        else $error("data register read wrong");

    a_write_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && hit_tag && hwrite && !hnonsec && !cache_enable |=>
        hreadyout && !hresp ##1 tag_ram_timing == ($past(hwdata) & TIMING_MASK))
        else $error("secure write did not update tag register");

    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((tag_ram_timing | data_ram_timing) & ~TIMING_MASK) == 32'h0000_0000)
        else $error("reserved bit set in latency register");

    a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
        acc_valid && !mapped |=> s_error_resp)
        else $error("unmapped address not refused");

endmodule
`default_nettype wire

// ==== sim/rlc_ram_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rlc_ram_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // ram strobes from the sequencer
    input  wire logic       ram_cs,
    input  wire logic       ram_we,
    // what the array saw of the last access
    output logic [4:0]      last_len,
    output logic            last_we
);
    logic [4:0] run_len;

    // ------------------------------------------------------------
    // array stand-in
    // ------------------------------------------------------------
    // the array has no feedback path, so only select time and kind matter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_len  <= 5'h00;
            last_len <= 5'h00;
            last_we  <= 1'h0;
        end else if (ram_cs) begin
            run_len <= run_len + 5'h01;
            last_we <= ram_we;
        end else if (run_len != 5'h00) begin
            last_len <= run_len; // length latched when select drops
            run_len  <= 5'h00;
        end
    end
endmodule
`default_nettype wire

// ==== sim/test_ram_latency_config.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_ram_latency_config;
    import rlc_pkg::*;

    typedef struct {
        logic [7:0]  a;
        logic        w;
        logic        ns;
        logic        cen;
        logic [31:0] wd;
        logic [31:0] rd;
        logic        rs;
    } rlc_row_t;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic              sys_clk;
    logic              rst_n;
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
    logic              hnonsec;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              cache_enable;
    logic              tag_req, tag_req_we, tag_ready, tag_done, tag_ram_cs, tag_ram_we;
    logic              data_req, data_req_we, data_ready, data_done, data_ram_cs, data_ram_we;
    logic [4:0]        tag_len, data_len;
    logic              tag_lwe, data_lwe;
    logic [31:0]       rd;
    logic              rs;
    int                n_mismatch;
    int                compares;

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    // tag and data reset codes differ so a swapped parameter shows;
    // data read code is left at its default so the default is exercised too
    rlc_top #(
        .TAG_SETUP_DELAY_PARAM (1),
        .TAG_READ_DELAY_PARAM  (2),
        .TAG_WRITE_DELAY_PARAM (3),
        .DATA_SETUP_DELAY_PARAM(4),
        .DATA_WRITE_DELAY_PARAM(6)
    ) i_rlc_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hnonsec(hnonsec), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cache_enable(cache_enable), .tag_req(tag_req), .tag_req_we(tag_req_we),
        .tag_ready(tag_ready), .tag_done(tag_done), .tag_ram_cs(tag_ram_cs),
        .tag_ram_we(tag_ram_we), .data_req(data_req), .data_req_we(data_req_we),
        .data_ready(data_ready), .data_done(data_done), .data_ram_cs(data_ram_cs),
        .data_ram_we(data_ram_we)
    );
    rlc_ram_model i_rlc_ram_model_tag (
        .sys_clk(sys_clk), .rst_n(rst_n), .ram_cs(tag_ram_cs), .ram_we(tag_ram_we),
        .last_len(tag_len), .last_we(tag_lwe)
    );
    rlc_ram_model i_rlc_ram_model_data (
        .sys_clk(sys_clk), .rst_n(rst_n), .ram_cs(data_ram_cs), .ram_we(data_ram_we),
        .last_len(data_len), .last_we(data_lwe)
    );

    // ------------------------------------------------------------
    // register bus cases: tag reset 0x321, data reset 0x604
    // ------------------------------------------------------------
    rlc_row_t rows [16] = '{
        '{TAG_TIMING_OFS,  1'h0, 1'h0, 1'h0, 32'h0, 32'h321, 1'h0},
        '{DATA_TIMING_OFS, 1'h0, 1'h1, 1'h0, 32'h0, 32'h604, 1'h0},
        '{TAG_TIMING_OFS,  1'h1, 1'h0, 1'h0, 32'hFFFF_FFFF, 32'h0, 1'h0},
        '{TAG_TIMING_OFS,  1'h0, 1'h1, 1'h0, 32'h0, 32'h777, 1'h0},
        '{TAG_TIMING_OFS,  1'h1, 1'h1, 1'h0, 32'h0, 32'h0, 1'h1},
        '{TAG_TIMING_OFS,  1'h0, 1'h0, 1'h0, 32'h0, 32'h777, 1'h0},
        '{DATA_TIMING_OFS, 1'h1, 1'h0, 1'h1, 32'h0, 32'h0, 1'h1},
        '{DATA_TIMING_OFS, 1'h0, 1'h0, 1'h1, 32'h0, 32'h604, 1'h0},
        '{ERR_STATUS_OFS,  1'h0, 1'h0, 1'h0, 32'h0, 32'h3, 1'h0},
        '{ERR_STATUS_OFS,  1'h1, 1'h0, 1'h0, 32'h3, 32'h0, 1'h0},
        '{ERR_STATUS_OFS,  1'h0, 1'h0, 1'h0, 32'h0, 32'h0, 1'h0},
        // non-secure write with cache on: only the decode-error cause is kept
        '{DATA_TIMING_OFS, 1'h1, 1'h1, 1'h1, 32'h0, 32'h0, 1'h1},
        '{ERR_STATUS_OFS,  1'h0, 1'h0, 1'h0, 32'h0, 32'h1, 1'h0},
        '{8'h0C,           1'h0, 1'h0, 1'h0, 32'h0, 32'h0, 1'h1},
        '{DATA_TIMING_OFS, 1'h1, 1'h0, 1'h0, 32'h0000_0106, 32'h0, 1'h0},
        '{DATA_TIMING_OFS, 1'h0, 1'h1, 1'h0, 32'h0, 32'h106, 1'h0}
    };

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ready is read at the falling edge, so it is the value the next rising edge sees
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (hreadyout !== 1'b1 && n < 20) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 20) check("bus wait", 32'h1, 32'h0);
    endtask

    // one single-word transfer; called just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic ns,
                       input logic [31:0] wd, output logic [31:0] rdv, output logic rsv);
        hsel    <= 1'h1;
        haddr   <= a;
        htrans  <= HTRANS_NONSEQ;
        hwrite  <= w;
        hnonsec <= ns;
        wait_ready();
        @(posedge sys_clk);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
        rsv = hresp;
        @(posedge sys_clk);
    endtask

    // one ram access: done cycle counted from the request cycle
    task automatic ram_op(input logic tg, input logic we, input int exp_done, input int exp_cs);
        int n;
        n = 0;
        tag_req     <= tg;
        data_req    <= !tg;
        tag_req_we  <= we;
        data_req_we <= we;
        @(negedge sys_clk);
        check("idle ready", {31'h0, tg ? tag_ready : data_ready}, 32'h1);
        @(posedge sys_clk);
        tag_req  <= 1'h0;
        data_req <= 1'h0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((tg ? tag_done : data_done) !== 1'b1 && n < 30);
        check("done cycle", 32'(n), 32'(exp_done));
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("select length", {27'h0, tg ? tag_len : data_len}, 32'(exp_cs));
        check("ram write", {31'h0, tg ? tag_lwe : data_lwe}, {31'h0, we});
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {rst_n, hsel, haddr, htrans, hwrite, hwdata, hnonsec, cache_enable} = '0;
        {tag_req, tag_req_we, data_req, data_req_we} = '0;
        hsize = 3'h2;
        n_mismatch = 0;
        compares = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        // reset codes: tag s1 r2 w3, data s4 r0 w6
        ram_op(1'h1, 1'h0, 6, 3);
        ram_op(1'h1, 1'h1, 7, 4);
        ram_op(1'h0, 1'h0, 7, 1);
        ram_op(1'h0, 1'h1, 13, 7);
        foreach (rows[i]) begin
            cache_enable <= rows[i].cen;
            bus(rows[i].a, rows[i].w, rows[i].ns, rows[i].wd, rd, rs);
            check("hresp", {31'h0, rs}, {31'h0, rows[i].rs});
            if (!rows[i].w && !rows[i].rs) check("hrdata", rd, rows[i].rd);
        end
        cache_enable <= 1'h0;
        // tag now at the top code, data at setup b110 and read b000
        ram_op(1'h1, 1'h0, 17, 8);
        ram_op(1'h1, 1'h1, 17, 8);
        ram_op(1'h0, 1'h0, 9, 1);
        ram_op(1'h0, 1'h1, 10, 2);
        // second reset in mid-run must bring back the parameter codes
        rst_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        bus(TAG_TIMING_OFS, 1'h0, 1'h0, 32'h0, rd, rs);
        check("tag after reset", rd, 32'h321);
        bus(DATA_TIMING_OFS, 1'h0, 1'h0, 32'h0, rd, rs);
        check("data after reset", rd, 32'h604);
        give_verdict();
    end
endmodule
`default_nettype wire
